// file: verilog/flash_seq_host.sv
// Host-side controller that programs and erases the flash over its strobe pins
// Operation
// - Program entry: two unlocks then program code
// - Half-page select is the byte LSB
// - Next load starts within 30 us
// - Page address bits held on every load
// - Chip erase is six writes ending 10h
// - Toggle strobe for each status read
// - Unlock writes AAh at 5555h, 55h at 2AAAh
`timescale 1ns/1ps
module flash_seq_host (
   input  wire logic                         clk_i,          // 40 MHz clock
   input  wire logic                         rst_i,          // Async reset, active high
   input  wire logic                         psel_i,         // APB select
   input  wire logic                         penable_i,      // APB enable
   input  wire logic                         pwrite_i,       // APB write
   input  wire logic [7:0]                   paddr_i,        // APB byte address
   input  wire logic [31:0]                  pwdata_i,       // APB write data
   output logic      [31:0]                  prdata_o,       // APB read data
   output logic                              pready_o,       // APB ready
   output logic                              pslverr_o,      // APB error
   output logic                              flash_ce_n_o,   // Chip select, low
   output logic                              flash_we_n_o,   // Write strobe, low
   output logic                              flash_oe_n_o,   // Output enable, low
   output logic      [flash_seq_pkg::ADDR_W-1:0] flash_addr_o, // Address A19..A0
   output logic                              flash_hps_o,    // Half-page select
   output logic      [flash_seq_pkg::DQ_W-1:0]   flash_dq_o,   // Data out
   output logic                              flash_dq_oe_o,  // Data drive enable
   input  wire logic [flash_seq_pkg::DQ_W-1:0]   flash_dq_i    // Data in
);
   import flash_seq_pkg::*;

   typedef enum logic [2:0] {S_IDLE, S_CMD, S_LOAD, S_GAP, S_POLL, S_READ} seq_state_t;
   typedef enum logic [1:0] {B_IDLE, B_SETUP, B_PULSE, B_HOLD} bus_state_t;

   seq_state_t         state_r;
   bus_state_t         bus_r;
   logic [OP_W-1:0]    op_r;
   logic [2:0]         step_r;
   logic [IDX_W-1:0]   idx_r;
   logic [IDX_W-1:0]   len_r;
   logic [IDX_W-1:0]   buf_idx_r;
   logic [BADDR_W-1:0] baddr_r;
   logic [GAP_W-1:0]   gap_r;
   logic [DIV_W-1:0]   div_r;
   logic [CNT_W-1:0]   cnt_r;
   logic [DQ_W-1:0]    status_byte_r;
   logic [DQ_W-1:0]    read_data_r;
   logic [DQ_W-1:0]    rd_byte_r;
   logic               rd_r;
   logic               pready_r;
   logic               pslverr_r;
   logic [31:0]        prdata_r;
   logic               ce_n_r, we_n_r, oe_n_r, dq_oe_r, hps_r;
   logic [ADDR_W-1:0]  pin_addr_r;
   logic [DQ_W-1:0]    dq_r;

   page_buf_if buf_bus ();

   page_buffer u_buf (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .buf_io (buf_bus.store)
   );

   // ----------------------------------------------------------------
   // APB decode
   // ----------------------------------------------------------------
   wire        setup_ph  = psel_i & ~penable_i;
   wire        wr_en     = psel_i & penable_i & pwrite_i & pready_r;
   wire        hit_ctrl  = paddr_i == REG_CTRL;
   wire        hit_addr  = paddr_i == REG_ADDR;
   wire        hit_len   = paddr_i == REG_LEN;
   wire        hit_idx   = paddr_i == REG_BUF_IDX;
   wire        hit_data  = paddr_i == REG_BUF_DATA;
   wire        hit_stat  = paddr_i == REG_STATUS;
   wire        mapped    = hit_ctrl | hit_addr | hit_len | hit_idx | hit_data | hit_stat;
   wire        busy      = state_r != S_IDLE;
   wire        fail      = status_byte_r[SR_EFAIL] | status_byte_r[SR_PFAIL];
   wire [OP_W-1:0] req_op = pwdata_i[OP_W-1:0];
   wire        start     = wr_en & hit_ctrl & pwdata_i[CTRL_GO_BIT] & ~busy & (req_op <= OP_LAST);
   wire [31:0] rd_mux    = hit_ctrl ? {28'h0000000, op_r} :
                           hit_addr ? {11'h000, baddr_r} :
                           hit_len  ? {25'h0000000, len_r} :
                           hit_idx  ? {25'h0000000, buf_idx_r} :
                           hit_stat ? {8'h00, read_data_r, status_byte_r, 6'h00, fail, busy} : 32'h00000000;

   assign buf_bus.we    = wr_en & hit_data;
   assign buf_bus.waddr = buf_idx_r;
   assign buf_bus.wdata = pwdata_i[DQ_W-1:0];
   assign buf_bus.raddr = idx_r;

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h00000000;
         baddr_r   <= 21'h000000;
         len_r     <= 7'h7f;
         buf_idx_r <= 7'h00;
      end else begin
         pready_r  <= setup_ph;
         pslverr_r <= setup_ph & ~mapped;
         prdata_r  <= setup_ph ? rd_mux : 32'h00000000;
         if (wr_en & hit_addr) baddr_r <= pwdata_i[BADDR_W-1:0];
         if (wr_en & hit_len) len_r <= pwdata_i[IDX_W-1:0];
         if (wr_en & hit_idx) buf_idx_r <= pwdata_i[IDX_W-1:0];
         else if (buf_bus.we) buf_idx_r <= buf_idx_r + 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Command words and cycle selection
   // ----------------------------------------------------------------
   wire              is_erase  = (op_r == OP_CHIP_ERASE) | (op_r == OP_SECTOR_ERASE);
   wire [2:0]        last_step = is_erase ? 3'd5 : 3'd2;
   wire [DQ_W-1:0]   code1     = (op_r == OP_PROGRAM)      ? CMD_PROGRAM :
                                 is_erase                  ? CMD_ERASE_SU :
                                 (op_r == OP_SUSPEND)      ? CMD_SUSPEND :
                                 (op_r == OP_RESUME)       ? CMD_RESUME :
                                 (op_r == OP_READ_STATUS)  ? CMD_RSTATUS :
                                 (op_r == OP_CLEAR_STATUS) ? CMD_CLEAR : CMD_RESET;
   wire [DQ_W-1:0]   code2     = (op_r == OP_CHIP_ERASE) ? CMD_CHIP : CMD_SECTOR;
   wire              unlock2   = (step_r == 3'd1) | (step_r == 3'd4);
   wire              sector_wr = (step_r == 3'd5) & (op_r == OP_SECTOR_ERASE);
   wire [ADDR_W-1:0] cmd_addr  = sector_wr ? {baddr_r[BADDR_W-1:17], 16'h0000} :
                                 {5'h00, unlock2 ? ADDR_UNLOCK2 : ADDR_UNLOCK1};
   wire [DQ_W-1:0]   cmd_data  = unlock2 ? CMD_UNLOCK2 :
                                 (step_r == 3'd2) ? code1 :
                                 (step_r == 3'd5) ? code2 : CMD_UNLOCK1;
   wire              cyc_rd    = (state_r == S_POLL) | (state_r == S_READ);
   wire              cyc_go    = (bus_r == B_IDLE) & (cyc_rd | (state_r == S_CMD) | (state_r == S_LOAD));
   wire [ADDR_W-1:0] cyc_addr  = (state_r == S_CMD) ? cmd_addr :
                                 (state_r == S_LOAD) ? {baddr_r[BADDR_W-1:7], idx_r[IDX_W-1:1]} :
                                 baddr_r[BADDR_W-1:1];
   wire              cyc_hps   = (state_r == S_CMD) ? 1'b0 :
                                 (state_r == S_LOAD) ? idx_r[0] : baddr_r[0];
   wire [DQ_W-1:0]   cyc_data  = (state_r == S_LOAD) ? buf_bus.rdata : cmd_data;
   wire              cnt_zero  = cnt_r == 4'h0;
   wire              cyc_done  = (bus_r == B_HOLD) & cnt_zero;
   wire              us_tick   = div_r == DIV_W'(CYC_PER_US - 1);
   wire [DQ_W-1:0]   sr_masked = rd_byte_r & SR_MASK;
   wire seq_state_t  after_cmd = (op_r == OP_PROGRAM) ? S_LOAD :
                                 (is_erase | (op_r == OP_SUSPEND)) ? S_POLL :
                                 ((op_r == OP_READ_STATUS) | (op_r == OP_READ_ARRAY)) ? S_READ : S_IDLE;

   // ----------------------------------------------------------------
   // Pin cycle engine
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         bus_r      <= B_IDLE;
         cnt_r      <= 4'h0;
         ce_n_r     <= 1'b1;
         we_n_r     <= 1'b1;
         oe_n_r     <= 1'b1;
         dq_oe_r    <= 1'b0;
         dq_r       <= 8'h00;
         pin_addr_r <= 20'h00000;
         hps_r      <= 1'b0;
         rd_r       <= 1'b0;
         rd_byte_r  <= 8'h00;
      end else if (bus_r != B_IDLE && !cnt_zero) begin
         cnt_r <= cnt_r - 1'b1;
      end else begin
         unique case (bus_r)
            B_IDLE: if (cyc_go) begin
               bus_r      <= B_SETUP;
               cnt_r      <= CNT_W'(AS_CYC - 1);
               pin_addr_r <= cyc_addr;
               hps_r      <= cyc_hps;
               rd_r       <= cyc_rd;
            end
            B_SETUP: begin
               bus_r   <= B_PULSE;
               cnt_r   <= rd_r ? CNT_W'(RD_CYC - 1) : CNT_W'(WP_CYC - 1);
               ce_n_r  <= 1'b0;
               we_n_r  <= rd_r;
               oe_n_r  <= ~rd_r;
               dq_r    <= cyc_data;
               dq_oe_r <= ~rd_r;
            end
            B_PULSE: begin
               bus_r  <= B_HOLD;
               cnt_r  <= CNT_W'(WH_CYC - 1);
               ce_n_r <= 1'b1;
               we_n_r <= 1'b1;
               oe_n_r <= 1'b1;
               if (rd_r) rd_byte_r <= flash_dq_i;
            end
            B_HOLD: begin
               bus_r   <= B_IDLE;
               dq_oe_r <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Operation sequencer
   // ----------------------------------------------------------------
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         div_r <= 6'h00;
      end else begin
         div_r <= us_tick ? 6'h00 : div_r + 1'b1;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         state_r       <= S_IDLE;
         op_r          <= OP_READ_ARRAY;
         step_r        <= 3'd0;
         idx_r         <= 7'h00;
         gap_r         <= 7'h00;
         status_byte_r <= 8'h80;
         read_data_r   <= 8'h00;
      end else begin
         unique case (state_r)
            S_IDLE: if (start) begin
               op_r    <= req_op;
               step_r  <= 3'd0;
               idx_r   <= 7'h00;
               state_r <= S_CMD;
            end
            S_CMD: if (cyc_done) begin
               if (step_r == last_step) state_r <= after_cmd;
               else step_r <= step_r + 1'b1;
            end
            S_LOAD: if (cyc_done) begin
               if (idx_r == len_r) begin
                  gap_r   <= 7'h00;
                  state_r <= S_GAP;
               end else begin
                  idx_r <= idx_r + 1'b1;
               end
            end
            S_GAP: begin
               if (gap_r == GAP_W'(GAP_TICKS)) state_r <= S_POLL;
               else if (us_tick) gap_r <= gap_r + 1'b1;
            end
            S_POLL: if (cyc_done) begin
               status_byte_r <= sr_masked;
               if (rd_byte_r[SR_READY]) state_r <= S_IDLE;
            end
            S_READ: if (cyc_done) begin
               if (op_r == OP_READ_STATUS) status_byte_r <= sr_masked;
               else read_data_r <= rd_byte_r;
               state_r <= S_IDLE;
            end
            default: state_r <= S_IDLE;
         endcase
      end
   end

   assign prdata_o      = prdata_r;
   assign pready_o      = pready_r;
   assign pslverr_o     = pslverr_r;
   assign flash_ce_n_o  = ce_n_r;
   assign flash_we_n_o  = we_n_r;
   assign flash_oe_n_o  = oe_n_r;
   assign flash_addr_o  = pin_addr_r;
   assign flash_hps_o   = hps_r;
   assign flash_dq_o    = dq_r;
   assign flash_dq_oe_o = dq_oe_r;

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   logic [12:0] gap_cyc_r;
   logic [10:0] since_rise_r;
   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         gap_cyc_r    <= 13'h0000;
         since_rise_r <= 11'h000;
      end else begin
         gap_cyc_r    <= (state_r == S_GAP) ? gap_cyc_r + 1'b1 : 13'h0000;
         since_rise_r <= !(state_r == S_LOAD && we_n_r) ? 11'h000 :
                         (since_rise_r == 11'h7ff) ? since_rise_r : since_rise_r + 1'b1;
      end
   end

   AST_OE_HIGH_ON_WRITE: assert property (!we_n_r |-> oe_n_r && !ce_n_r && dq_oe_r)
      else $error("write strobe with output enable low");
   AST_PROGRAM_CODE: assert property ($fell(we_n_r) && state_r == S_CMD && step_r == 3'd2 && op_r == OP_PROGRAM
      |-> dq_r == CMD_PROGRAM && pin_addr_r[14:0] == ADDR_UNLOCK1)
      else $error("program command word wrong");
   AST_UNLOCK_PAIR: assert property ($fell(we_n_r) && state_r == S_CMD && step_r == 3'd1
      |-> dq_r == CMD_UNLOCK2 && pin_addr_r[14:0] == ADDR_UNLOCK2)
      else $error("second unlock write wrong");
   AST_CHIP_LAST: assert property ($fell(we_n_r) && state_r == S_CMD && step_r == 3'd5 && op_r == OP_CHIP_ERASE
      |-> dq_r == CMD_CHIP)
      else $error("chip erase final code wrong");
   AST_SECTOR_ADDR: assert property ($fell(we_n_r) && sector_wr
      |-> dq_r == CMD_SECTOR && pin_addr_r[19:16] == baddr_r[20:17])
      else $error("sector erase address or code wrong");
   AST_LOAD_ADDR: assert property ($fell(we_n_r) && state_r == S_LOAD
      |-> pin_addr_r == {baddr_r[20:7], idx_r[6:1]} && flash_hps_o == idx_r[0])
      else $error("byte load address wrong");
   AST_LOAD_SPACING: assert property ($fell(we_n_r) && state_r == S_LOAD |-> since_rise_r < 11'(LOAD_MAX_CYC))
      else $error("byte loads too far apart");
   AST_QUIET_GAP: assert property (state_r == S_GAP ##1 state_r == S_POLL |-> gap_cyc_r > 13'(LOAD_END_CYC))
      else $error("load period ended too soon");
   AST_READ_PULSE: assert property ($fell(oe_n_r) |-> (!oe_n_r && !ce_n_r) [*8] ##1 (oe_n_r && ce_n_r))
      else $error("read strobe width wrong");
   AST_POLL_READY: assert property (state_r == S_POLL && cyc_done && rd_byte_r[SR_READY]
      |=> state_r == S_IDLE && status_byte_r == $past(sr_masked))
      else $error("poll did not finish on ready");

   COV_PROGRAM: cover property (state_r == S_GAP ##1 state_r == S_POLL);
   COV_SUSPEND: cover property (state_r == S_POLL && op_r == OP_SUSPEND && cyc_done && rd_byte_r[SR_READY]);
   COV_SECTOR:  cover property ($fell(we_n_r) && sector_wr);
endmodule : flash_seq_host

// file: verilog/flash_seq_pkg.sv
// Constants for the flash program/erase sequencer controller
package flash_seq_pkg;

   // ----------------------------------------------------------------
   // Clock and pin timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int T_AS_NS       = 25;
   localparam int T_WP_NS       = 100;
   localparam int T_WH_NS       = 50;
   localparam int T_RD_NS       = 200;
   localparam int AS_CYC        = (T_AS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WP_CYC        = (T_WP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int WH_CYC        = (T_WH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int RD_CYC        = (T_RD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int US_NS         = 1000;
   localparam int CYC_PER_US    = US_NS / CLK_PERIOD_NS;
   localparam int LOAD_END_US   = 100;
   localparam int LOAD_MAX_US   = 30;
   localparam int GAP_TICKS     = LOAD_END_US + 1;
   localparam int LOAD_END_CYC  = LOAD_END_US * CYC_PER_US;
   localparam int LOAD_MAX_CYC  = LOAD_MAX_US * CYC_PER_US;
   localparam int CNT_W         = 4;
   localparam int DIV_W         = 6;
   localparam int GAP_W         = 7;

   // ----------------------------------------------------------------
   // Widths
   // ----------------------------------------------------------------
   localparam int DQ_W       = 8;
   localparam int ADDR_W     = 20;
   localparam int BADDR_W    = 21;
   localparam int IDX_W      = 7;
   localparam int PAGE_BYTES = 128;
   localparam int OP_W       = 4;
   localparam int CMDA_W     = 15;

   // ----------------------------------------------------------------
   // APB register map
   // ----------------------------------------------------------------
   localparam logic [7:0] REG_CTRL     = 8'h00;
   localparam logic [7:0] REG_ADDR     = 8'h04;
   localparam logic [7:0] REG_LEN      = 8'h08;
   localparam logic [7:0] REG_BUF_IDX  = 8'h0c;
   localparam logic [7:0] REG_BUF_DATA = 8'h10;
   localparam logic [7:0] REG_STATUS   = 8'h14;
   localparam int         CTRL_GO_BIT  = 31;

   // ----------------------------------------------------------------
   // Operations
   // ----------------------------------------------------------------
   localparam logic [OP_W-1:0] OP_PROGRAM      = 4'h0;
   localparam logic [OP_W-1:0] OP_CHIP_ERASE   = 4'h1;
   localparam logic [OP_W-1:0] OP_SECTOR_ERASE = 4'h2;
   localparam logic [OP_W-1:0] OP_SUSPEND      = 4'h3;
   localparam logic [OP_W-1:0] OP_RESUME       = 4'h4;
   localparam logic [OP_W-1:0] OP_READ_STATUS  = 4'h5;
   localparam logic [OP_W-1:0] OP_CLEAR_STATUS = 4'h6;
   localparam logic [OP_W-1:0] OP_READ_ARRAY   = 4'h7;
   localparam logic [OP_W-1:0] OP_LAST         = 4'h7;

   // ----------------------------------------------------------------
   // Device command codes and status layout
   // ----------------------------------------------------------------
   localparam logic [CMDA_W-1:0] ADDR_UNLOCK1 = 15'h5555;
   localparam logic [CMDA_W-1:0] ADDR_UNLOCK2 = 15'h2aaa;
   localparam logic [DQ_W-1:0]   CMD_UNLOCK1  = 8'haa;
   localparam logic [DQ_W-1:0]   CMD_UNLOCK2  = 8'h55;
   localparam logic [DQ_W-1:0]   CMD_PROGRAM  = 8'ha0;
   localparam logic [DQ_W-1:0]   CMD_ERASE_SU = 8'h80;
   localparam logic [DQ_W-1:0]   CMD_CHIP     = 8'h10;
   localparam logic [DQ_W-1:0]   CMD_SECTOR   = 8'h30;
   localparam logic [DQ_W-1:0]   CMD_SUSPEND  = 8'hb0;
   localparam logic [DQ_W-1:0]   CMD_RESUME   = 8'hd0;
   localparam logic [DQ_W-1:0]   CMD_RSTATUS  = 8'h70;
   localparam logic [DQ_W-1:0]   CMD_CLEAR    = 8'h50;
   localparam logic [DQ_W-1:0]   CMD_RESET    = 8'hf0;
   localparam logic [DQ_W-1:0]   SR_MASK      = 8'hfc;
   localparam int                SR_READY     = 7;
   localparam int                SR_SUSPEND   = 6;
   localparam int                SR_EFAIL     = 5;
   localparam int                SR_PFAIL     = 4;

endpackage : flash_seq_pkg

// file: verilog/page_buf_if.sv
// Interface between the sequencer and its page buffer
`timescale 1ns/1ps
interface page_buf_if;
   import flash_seq_pkg::*;
   logic             we;
   logic [IDX_W-1:0] waddr;
   logic [DQ_W-1:0]  wdata;
   logic [IDX_W-1:0] raddr;
   logic [DQ_W-1:0]  rdata;

   modport client (output we, output waddr, output wdata, output raddr, input rdata);
   modport store  (input we, input waddr, input wdata, input raddr, output rdata);
endinterface : page_buf_if

// file: verilog/page_buffer.sv
// Page buffer: one page of bytes, registered read
`timescale 1ns/1ps
module page_buffer (
   input  wire logic         clk_i,   // System clock
   input  wire logic         rst_i,   // Async reset, active high
   page_buf_if.store         buf_io   // Write and read ports
);
   import flash_seq_pkg::*;

   logic [DQ_W-1:0] mem_r [PAGE_BYTES];
   logic [DQ_W-1:0] rdata_r;

   always_ff @(posedge clk_i) begin
      if (buf_io.we) begin
         mem_r[buf_io.waddr] <= buf_io.wdata;
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_r <= 8'h00;
      end else begin
         rdata_r <= mem_r[buf_io.raddr];
      end
   end

   assign buf_io.rdata = rdata_r;
endmodule : page_buffer

// file: dv/flash_dev_model.sv
// Behavioural flash device answering the sequencer's strobes
`timescale 1ns/1ps
module flash_dev_model #(parameter int BUSY_NS = 3000, parameter int LOAD_END_NS = 100000) (
   input  wire logic        ce_n_i,   // Chip select, low
   input  wire logic        we_n_i,   // Write strobe, low
   input  wire logic        oe_n_i,   // Output enable, low
   input  wire logic [19:0] addr_i,   // A19..A0
   input  wire logic        hps_i,    // Half-page select
   input  wire logic [7:0]  dq_i,     // Data from host
   input  wire logic        dq_oe_i,  // Host drives data
   output logic      [7:0]  dq_o      // Data to host
);
   logic [7:0]  mem [logic [20:0]];
   logic [7:0]  sr = 8'h80;
   logic [7:0]  last = 8'h00;
   logic [20:0] la;
   int          step = 0, ld_id = 0;
   bit          stat = 0, prog = 0, erase = 0;
   wire         wr = ce_n_i | we_n_i;
   wire         rd = ce_n_i | oe_n_i;
   function automatic logic [7:0] rdv(input logic [20:0] k);
      return mem.exists(k) ? mem[k] : 8'hff;
   endfunction : rdv
   task automatic run(input bit er, input logic [3:0] s, input bit chip);
      logic [20:0] ks[$];
      sr[7] = 0;
      erase = er;
      repeat (10) begin
         #(BUSY_NS / 10);
         wait (!sr[6]);
      end
      foreach (mem[k]) if (er && (chip || k[20:17] == s)) ks.push_back(k);
      foreach (ks[i]) mem.delete(ks[i]);
      erase = 0;
      sr[7] = 1;
   endtask : run
   task automatic quiet(input int id);
      #(LOAD_END_NS);
      if (id == ld_id) begin
         prog = 0;
         run(0, 0, 0);
      end
   endtask : quiet
   task automatic cmd(input logic [20:0] a, input logic [7:0] d);
      logic [14:0] ca;
      ca = a[15:1];
      if (prog) begin
         mem[a] = d;
         ld_id++;
         fork quiet(ld_id); join_none
      end else if (step == 0 || step == 3)
         step = (ca == 15'h5555 && d == 8'haa) ? step + 1 : 0;
      else if (step == 1 || step == 4)
         step = (ca == 15'h2aaa && d == 8'h55) ? step + 1 : 0;
      else if (step == 5) begin
         step = 0;
         stat = 1;
         if (d == 8'h10 && ca == 15'h5555) fork run(1, 0, 1); join_none
         if (d == 8'h30) fork run(1, a[20:17], 0); join_none
      end else begin
         step = 0;
         if (ca != 15'h5555 || (sr[6] && !(d inside {8'hf0, 8'h70, 8'hd0}))) return;
         case (d)
            8'ha0: {prog, stat} = 2'b11;
            8'h80: step = 3;
            8'hb0: if (erase) sr[7:6] = 2'b11;
            8'hd0: if (sr[6]) sr[7:6] = 2'b00;
            8'h70: stat = 1;
            8'h50: sr[5:4] = 2'b00;
            8'hf0: {stat, sr[2]} = 2'b00;
            default: step = 0;
         endcase
      end
   endtask : cmd
   always @(negedge wr) la = {addr_i, hps_i};
   always @(posedge wr) if (oe_n_i === 1'b1 && dq_oe_i === 1'b1) cmd(la, dq_i);
   always @(negedge rd) last = stat ? (sr & 8'hfc) : rdv({addr_i, hps_i});
   assign dq_o = (rd === 1'b0) ? last : ~last;
endmodule : flash_dev_model

// file: dv/flash_program_erase_sequencer_test.sv
// Self-checking bench for the flash sequencer host
`timescale 1ns/1ps
module flash_program_erase_sequencer_test;
   import flash_seq_pkg::*;
   localparam logic [20:0] BASE = 21'h040100;
   logic        clk_i = 0, rst_i = 1, psel = 0, penable = 0, pwrite = 0, perr;
   logic [7:0]  paddr = 0, dq_o, dq_i;
   logic [31:0] pwdata = 0, prdata, q;
   logic        pready, pslverr, ce_n, we_n, oe_n, hps, dq_oe;
   logic [19:0] addr;
   logic [7:0]  pat [3] = '{8'h5a, 8'hc3, 8'h81};
   int          error_cnt = 0, n_compared = 0;
   always #12.5 clk_i = ~clk_i;
   flash_seq_host DUT (.clk_i(clk_i), .rst_i(rst_i), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr),
      .flash_ce_n_o(ce_n), .flash_we_n_o(we_n), .flash_oe_n_o(oe_n), .flash_addr_o(addr),
      .flash_hps_o(hps), .flash_dq_o(dq_o), .flash_dq_oe_o(dq_oe), .flash_dq_i(dq_i));
   flash_dev_model dev (.ce_n_i(ce_n), .we_n_i(we_n), .oe_n_i(oe_n), .addr_i(addr), .hps_i(hps),
      .dq_i(dq_o), .dq_oe_i(dq_oe), .dq_o(dq_i));
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_i);
      {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
      @(posedge clk_i);
      penable <= 1;
      do @(posedge clk_i); while (pready !== 1'b1);
      q = prdata;
      perr = pslverr;
      {psel, penable} <= 2'b00;
   endtask : apb
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("wrong value %s expected %h seen %h", n, e, g);
      end
   endtask : chk
   task automatic rchk(input string n, input logic [31:0] m, input logic [31:0] e);
      apb(0, REG_STATUS, 0);
      chk(n, e, q & m);
   endtask : rchk
   task automatic go(input logic [3:0] op, input logic [20:0] a);
      apb(1, REG_ADDR, {11'h000, a});
      apb(1, REG_CTRL, {28'h8000000, op});
      repeat (3000) begin
         apb(0, REG_STATUS, 0);
         if (q[0] === 1'b0) break;
      end
      chk("operation finished", 32'h0, q & 32'h1);
   endtask : go
   task automatic conclude;
      $display("compared %0d mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask : conclude
   initial begin
      repeat (60000) @(posedge clk_i);
      error_cnt++;
      conclude();
   end
   initial begin
      repeat (8) @(posedge clk_i);
      rst_i <= 0;
      rchk("status at reset", 32'hffff, 32'h8000);
      apb(1, REG_LEN, 2);
      apb(1, REG_BUF_IDX, 0);
      for (int i = 0; i < 3; i++) apb(1, REG_BUF_DATA, {24'h0, pat[i]});
      go(OP_PROGRAM, BASE);
      rchk("program status", 32'hffff, 32'h8000);
      for (int i = 0; i < 3; i++) chk("loaded byte", pat[i], dev.rdv(BASE + i));
      chk("unloaded byte", 8'hff, dev.rdv(BASE + 3));
      go(OP_READ_ARRAY, BASE + 1);
      rchk("array read", 32'hff0000, 32'hc30000);
      go(OP_READ_STATUS, 0);
      rchk("status read", 32'hffff, 32'h8000);
      $display("test program done");
      dev.mem[21'h10] = 8'h11;
      go(OP_SECTOR_ERASE, BASE);
      chk("erased sector", 8'hff, dev.rdv(BASE));
      chk("other sector", 8'h11, dev.rdv(21'h10));
      go(OP_CHIP_ERASE, 0);
      chk("chip erased", 8'hff, dev.rdv(21'h10));
      $display("test erase done");
      go(OP_SUSPEND, 0);
      go(OP_RESUME, 0);
      go(OP_READ_STATUS, 0);
      rchk("idle suspend", 32'hffff, 32'h8000);
      dev.sr[4] = 1'b1;
      go(OP_READ_STATUS, 0);
      rchk("fail flag", 32'h2, 32'h2);
      go(OP_CLEAR_STATUS, 0);
      go(OP_READ_STATUS, 0);
      rchk("fail cleared", 32'hffff, 32'h8000);
      apb(0, 8'h40, 0);
      chk("unmapped error", 1, perr);
      $display("test status done");
      conclude();
   end
endmodule : flash_program_erase_sequencer_test
